// >>> drs_refresh_ctrl.sv
// What this block does
// - CS, RAS, CAS low and WE high at clock rise starts one refresh cycle.
// - Internal row counter supplies addresses; all banks idle when refresh ends.
// - CS, RAS, CAS, CKE low with WE high enters self-refresh.
// - CKE held low in self-refresh; other controls except reset ignored.
// - With DLL enabled, DLL off on entry, back on with reset at exit.
// - At least one internal refresh within tCKE after entering self-refresh.
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.svh"
module drs_refresh_ctrl
   import drs_pkg::*;
(
   input wire logic ref_clk_i,                   // System clock, 50 MHz
   input wire logic reset_i,                     // Synchronous reset, active high
   input wire logic ck_i,                        // Memory link clock from controller
   input wire logic cs_n_i,                      // Chip select, active low
   input wire logic ras_n_i,                     // Row strobe, active low
   input wire logic cas_n_i,                     // Column strobe, active low
   input wire logic we_n_i,                      // Write enable, active low
   input wire logic cke_i,                       // Clock enable
   input wire logic dll_en_i,                    // Mode bit: DLL in use
   output logic refresh_busy_o,                  // Refresh cycle running
   output logic self_refresh_o,                  // Device in self-refresh
   output logic [`DRS_ROW_W-1:0] refresh_row_o,  // Row being refreshed
   output logic refresh_pulse_o,                 // One-cycle pulse per refresh
   output logic dll_on_o,                        // DLL running
   output logic dll_reset_o                      // DLL reset in progress
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Stage 1 feeds only stage 2; decisions use stages 2 and 3
   logic [5:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
   logic [5:0] pin_w;
   logic ck_rise_w;
   logic cs_n_w, ras_n_w, cas_n_w, we_n_w, cke_w;
   logic cmd_ref_w, cmd_sre_w, cmd_srx_w;

   assign pin_w = {cke_i, we_n_i, cas_n_i, ras_n_i, cs_n_i, ck_i};

   always_comb begin
      s1_d = pin_w;
      s2_d = s1_q;
      s3_d = s2_q;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         s1_q <= `DRS_PIN_IDLE;
         s2_q <= `DRS_PIN_IDLE;
         s3_q <= `DRS_PIN_IDLE;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end

   // ==========================================================
   // Pin filter
   // ==========================================================
   // A pin counts as changed once stages 2 and 3 agree; a value seen by stage 2
   // alone is never acted on, at the cost of one more cycle of latency
   logic [5:0] flt_q, flt_d;
   logic ref_code_w;

   always_comb begin
      flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         flt_q <= `DRS_PIN_IDLE;
      end else begin
         flt_q <= flt_d;
      end
   end

   // Refresh and self-refresh entry share one pin pattern; CKE tells them apart
   function automatic logic drs_is_ref_code(input logic [3:0] pins);
      drs_is_ref_code = (pins == 4'h1);
   endfunction : drs_is_ref_code

   // Link clock edge: second and third stages agree on a new high
   assign ck_rise_w = flt_d[0] & ~flt_q[0];
   assign cs_n_w = flt_d[1];
   assign ras_n_w = flt_d[2];
   assign cas_n_w = flt_d[3];
   assign we_n_w = flt_d[4];
   assign cke_w = flt_d[5];

   // Command bus is sampled only on a link clock rise; setup assumed ahead of it
   assign ref_code_w = drs_is_ref_code({cs_n_w, ras_n_w, cas_n_w, we_n_w});
   assign cmd_ref_w = ck_rise_w & ref_code_w & cke_w;
   assign cmd_sre_w = ck_rise_w & ref_code_w & ~cke_w;
   // In self-refresh the link clock may be stopped, so exit is the CKE level alone
   assign cmd_srx_w = cke_w;

   // ==========================================================
   // Refresh state machine
   // ==========================================================
   drs_state_t state_q, state_d;
   logic [`DRS_CNT_W-1:0] cnt_q, cnt_d;
   logic [`DRS_CNT_W-1:0] sr_tmr_q, sr_tmr_d;
   logic [`DRS_CNT_W-1:0] dll_cnt_q, dll_cnt_d;
   logic [`DRS_ROW_W-1:0] row_q, row_d;
   logic pulse_q, pulse_d;
   logic dll_on_q, dll_on_d;
   logic dll_rst_q, dll_rst_d;

   function automatic logic [`DRS_CNT_W-1:0] drs_dec(input logic [`DRS_CNT_W-1:0] v);
      drs_dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
   endfunction : drs_dec

   // Internal row counter; wraps, as every row is refreshed in turn
   function automatic logic [`DRS_ROW_W-1:0] drs_next_row(input logic [`DRS_ROW_W-1:0] r);
      drs_next_row = r + 16'h0001;
   endfunction : drs_next_row

   always_comb begin
      state_d = state_q;
      cnt_d = drs_dec(cnt_q);
      sr_tmr_d = sr_tmr_q;
      dll_cnt_d = drs_dec(dll_cnt_q);
      row_d = row_q;
      pulse_d = 1'b0;
      dll_on_d = dll_on_q;
      dll_rst_d = dll_rst_q & (dll_cnt_q != 16'h0000);
      case (state_q)
         DRS_IDLE: begin
            if (cmd_ref_w) begin
               // Address bus not looked at; row from internal counter
               state_d = DRS_REFRESH;
               cnt_d = 16'(`DRS_TRFC_CYC);
               row_d = drs_next_row(row_q);
               pulse_d = 1'b1;
            end else if (cmd_sre_w) begin
               state_d = DRS_SELF_REF;
               // First internal refresh starts at once, well within tCKE
               sr_tmr_d = 16'h0000;
               if (dll_en_i) begin
                  dll_on_d = 1'b0;
               end
            end
         end
         DRS_REFRESH: begin
            // Further commands are the controller's to hold off for tRFC
            if (cnt_q == 16'h0000) begin
               state_d = DRS_IDLE;
            end
         end
         DRS_SELF_REF: begin
            sr_tmr_d = drs_dec(sr_tmr_q);
            if (sr_tmr_q == 16'h0000) begin
               state_d = DRS_SR_REFRESH;
               cnt_d = 16'(`DRS_TRFC_CYC);
               row_d = drs_next_row(row_q);
               pulse_d = 1'b1;
            end else if (cmd_srx_w) begin
               state_d = DRS_IDLE;
               if (dll_en_i) begin
                  dll_on_d = 1'b1;
                  dll_rst_d = 1'b1;
                  dll_cnt_d = 16'(`DRS_DLL_RESET_CYC);
               end
            end
         end
         DRS_SR_REFRESH: begin
            // An exit during an internal refresh waits it out; tXS covers this
            if (cnt_q == 16'h0000) begin
               state_d = DRS_SELF_REF;
               sr_tmr_d = 16'(`DRS_SR_TREFI_CYC);
            end
         end
         default: begin
            state_d = DRS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_q <= DRS_IDLE;
         cnt_q <= 16'h0000;
         sr_tmr_q <= 16'h0000;
         dll_cnt_q <= 16'h0000;
         row_q <= 16'h0000;
         pulse_q <= 1'b0;
         dll_on_q <= 1'b1;
         dll_rst_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sr_tmr_q <= sr_tmr_d;
         dll_cnt_q <= dll_cnt_d;
         row_q <= row_d;
         pulse_q <= pulse_d;
         dll_on_q <= dll_on_d;
         dll_rst_q <= dll_rst_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign refresh_busy_o = (state_q == DRS_REFRESH) | (state_q == DRS_SR_REFRESH);
   assign self_refresh_o = (state_q == DRS_SELF_REF) | (state_q == DRS_SR_REFRESH);
   assign refresh_row_o = row_q;
   assign refresh_pulse_o = pulse_q;
   assign dll_on_o = dll_on_q;
   assign dll_reset_o = dll_rst_q;

endmodule : drs_refresh_ctrl
`default_nettype wire

// >>> drs_defines.svh
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH
// Row counter width and refresh timing, in ref_clk_i cycles at 50 MHz
`define DRS_ROW_W 16
`define DRS_CLK_PERIOD_NS 20
`define DRS_TRFC_NS 160
`define DRS_TRFC_CYC ((`DRS_TRFC_NS + `DRS_CLK_PERIOD_NS - 1) / `DRS_CLK_PERIOD_NS)
`define DRS_TCKE_NS 5000
`define DRS_TCKE_CYC (`DRS_TCKE_NS / `DRS_CLK_PERIOD_NS)
`define DRS_SR_TREFI_NS 7800
`define DRS_SR_TREFI_CYC (`DRS_SR_TREFI_NS / `DRS_CLK_PERIOD_NS)
`define DRS_DLL_RESET_NS 10240
`define DRS_DLL_RESET_CYC (`DRS_DLL_RESET_NS / `DRS_CLK_PERIOD_NS)
`define DRS_CNT_W 16
// Synchroniser reset: CKE high, command pins deselected, link clock low
`define DRS_PIN_IDLE 6'h3E
`endif

// >>> drs_pkg.sv
`default_nettype none
package drs_pkg;
   typedef enum logic [2:0] {
      DRS_IDLE,
      DRS_REFRESH,
      DRS_SELF_REF,
      DRS_SR_REFRESH
   } drs_state_t;
endpackage : drs_pkg
`default_nettype wire

// >>> drs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.svh"
module drs_props (
   input wire logic ref_clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic ck_i, // Link clock
   input wire logic cs_n_i, // Command
   input wire logic ras_n_i, // Command
   input wire logic cas_n_i, // Command
   input wire logic we_n_i, // Command
   input wire logic cke_i, // Clock enable
   input wire logic dll_en_i, // Mode
   input wire logic refresh_busy_o, // Output
   input wire logic self_refresh_o, // Output
   input wire logic [`DRS_ROW_W-1:0] refresh_row_o, // Output
   input wire logic refresh_pulse_o, // Output
   input wire logic dll_on_o, // Output
   input wire logic dll_reset_o // Output
);
   localparam int TCKE_CYC = `DRS_TCKE_CYC;
   // ========
   // Checks
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_sr_in;
      $rose(self_refresh_o);
   endsequence
   // One refresh cycle: busy for tRFC plus the closing cycle, then idle again
   sequence s_busy_window;
      refresh_busy_o [*8] ##1 refresh_busy_o ##1 !refresh_busy_o;
   endsequence
   a_pulse_opens: assert property ($rose(refresh_busy_o) |-> refresh_pulse_o)
      else $error("busy without pulse");
   a_pulse_single: assert property (refresh_pulse_o |=> !refresh_pulse_o)
      else $error("long pulse");
   a_busy_stands: assert property ($rose(refresh_busy_o) |-> s_busy_window)
      else $error("short refresh");
   a_row_steps: assert property (refresh_pulse_o |->
      refresh_row_o == $past(refresh_row_o) + 1'b1) else $error("row not stepped");
   a_dll_off_entry: assert property (s_sr_in ##0 $past(dll_en_i) |-> !dll_on_o)
      else $error("dll on in self-refresh");
   a_dll_exit_reset: assert property ($fell(self_refresh_o) && dll_en_i |->
      dll_on_o && dll_reset_o) else $error("dll not reset on exit");
   a_sr_first_ref: assert property (s_sr_in |-> ##[0:TCKE_CYC] refresh_pulse_o)
      else $error("no internal refresh");
   a_sr_holds: assert property ((self_refresh_o && !cke_i) [*5] |=> self_refresh_o)
      else $error("left self-refresh with cke low");
endmodule : drs_props
bind drs_refresh_ctrl drs_props u_props (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ck_i(ck_i), .cs_n_i(cs_n_i),
   .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .cke_i(cke_i),
   .dll_en_i(dll_en_i), .refresh_busy_o(refresh_busy_o), .self_refresh_o(self_refresh_o),
   .refresh_row_o(refresh_row_o), .refresh_pulse_o(refresh_pulse_o), .dll_on_o(dll_on_o),
   .dll_reset_o(dll_reset_o));
`default_nettype wire

// >>> drs_mc_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.svh"
module drs_mc_model (
   input wire logic clk_i, // Bench clock
   output logic ck_o, // Link clock
   output logic cs_n_o, // Select
   output logic ras_n_o, // Row strobe
   output logic cas_n_o, // Column strobe
   output logic we_n_o, // Write
   output logic cke_o // Clock enable
);
   // ========
   // Frames: link clock only runs within a frame, so it stands still between frames, also in self-refresh
   // No termination pin is driven: termination stays off throughout
   int owed = 0;
   int sent = 0;
   int tick = 0;
   initial begin
      ck_o = 1'b0;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o} = 5'h1F;
   end
   // Refresh debt: one owed per tREFI with CKE high, frozen while CKE is low
   always @(posedge clk_i) begin
      if (cke_o) begin
         tick <= (tick == `DRS_SR_TREFI_CYC - 1) ? 0 : tick + 1;
         if (tick == `DRS_SR_TREFI_CYC - 1) owed <= owed + 1;
      end
   end
   task automatic frame(input logic [3:0] c, input logic k);
      @(negedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
      cke_o = k;
      if (c == 4'h1 && k) sent++;
      repeat (4) @(negedge clk_i);
      ck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      ck_o = 1'b0;
      repeat (3) @(negedge clk_i);
      // Deselected lines must not keep a stale command
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = ~{ras_n_o, cas_n_o, we_n_o};
   endtask : frame
endmodule : drs_mc_model
`default_nettype wire

// >>> drs_refresh_self_refresh_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.svh"
module drs_refresh_self_refresh_tb;
   logic clk, rst, ck, cs_n, ras_n, cas_n, we_n, cke, dll_en;
   logic busy, sr, pulse, dll_on, dll_rst;
   logic [`DRS_ROW_W-1:0] row;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_pulse = 0;
   int cyc = 0;
   int exp_n = 0;
   // Rows: {cs, ras, cas, we, refresh expected}; one refresh keeps within 16 per 2 tREFI
   logic [4:0] rows [5] = '{5'h03, 5'h06, 5'h04, 5'h12, 5'h08};
   drs_refresh_ctrl u_dut (.ref_clk_i(clk), .reset_i(rst), .ck_i(ck), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke), .dll_en_i(dll_en),
      .refresh_busy_o(busy), .self_refresh_o(sr), .refresh_row_o(row),
      .refresh_pulse_o(pulse), .dll_on_o(dll_on), .dll_reset_o(dll_rst));
   drs_mc_model u_mc (.clk_i(clk), .ck_o(ck), .cs_n_o(cs_n), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .we_n_o(we_n), .cke_o(cke));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pulse === 1'b1) n_pulse <= n_pulse + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic issue(input logic [3:0] c, input logic k);
      u_mc.frame(c, k);
      repeat (8) @(negedge clk);
   endtask : issue
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // ========
   // Sequence
   initial begin
      rst = 1'b1;
      dll_en = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(16'({busy, sr, pulse, dll_on, dll_rst}), 16'h0002);
      chk(row, 16'h0000);
      foreach (rows[i]) begin
         issue(rows[i][4:1], 1'b1);
         exp_n += int'(rows[i][0]);
         chk(16'(n_pulse), 16'(exp_n));
         chk(row, 16'(exp_n));
      end
      for (int d = 1; d >= 0; d--) begin
         dll_en = d[0];
         issue(4'h1, 1'b0);
         exp_n++;
         repeat (180) @(negedge clk);
         chk(16'({sr, dll_on}), 16'({1'b1, ~d[0]}));
         chk(16'(n_pulse), 16'(exp_n));
         issue(4'h1, 1'b0);
         repeat (380) @(negedge clk);
         exp_n++;
         chk(16'(n_pulse), 16'(exp_n));
         issue(4'hF, 1'b1);
         chk(16'({sr, dll_on, dll_rst & d[0]}), 16'({2'b01, d[0]}));
         repeat (520) @(negedge clk);
         chk(16'(dll_rst), 16'h0);
         issue(4'h1, 1'b1);
         exp_n++;
         chk(row, 16'(exp_n));
      end
      // Reset in mid-run with the row counter away from zero, then a refresh at once
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(16'({busy, sr, pulse, dll_on, dll_rst}), 16'h0002);
      chk(row, 16'h0000);
      issue(4'h1, 1'b1);
      chk(row, 16'h0001);
      chk(16'((u_mc.owed - u_mc.sent) inside {[-8:8]}), 16'h0001);
      end_of_test();
   end
endmodule : drs_refresh_self_refresh_tb
`default_nettype wire
